// ===== verilog/csg_defs.svh
// Purpose: Offsets, field positions, reset values and bounds for the
//          status and stack guard block.
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word.
// Notes:   Definitions only.
`ifndef CSG_DEFS_SVH
`define CSG_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CSG_SR_OFS 8'h00
`define CSG_CORE_OFS 8'h04
`define CSG_INTC_OFS 8'h08
`define CSG_SP_OFS 8'h0c
`define CSG_LIM_OFS 8'h10

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define CSG_SR_SATA 13
`define CSG_SR_SATB 12
`define CSG_SR_SATAB 10
`define CSG_SR_IPL_HI 7
`define CSG_SR_IPL_LO 5
`define CSG_SR_RA 4
`define CSG_SR_N 3
`define CSG_SR_OV 2
`define CSG_SR_Z 1
`define CSG_SR_C 0

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CSG_CORE_PMSB 3
`define CSG_INTC_NSTD 15
`define CSG_INTC_STKE 2

// ----------------------------------------------------------------------
// Stack and priority constants
// ----------------------------------------------------------------------
`define CSG_STACK_FLOOR 16'h0800
`define CSG_STACK_STEP 16'h0002
`define CSG_IPL_TOP 3'h7

`endif

// ===== verilog/csg_pkg.sv
// Purpose: Types shared by the status and stack guard modules.
// Assumes: Nothing beyond the defines header.
// Notes:   Push kinds select how the pushed word is formed.
package csg_pkg;

  typedef enum logic [1:0] {
    CSG_PUSH_DATA  = 2'b00,
    CSG_PUSH_PCLO  = 2'b01,
    CSG_PUSH_CALLHI = 2'b11,
    CSG_PUSH_EXCHI = 2'b10
  } csg_push_e;

  typedef logic [15:0] csg_word_t;

endpackage

// ===== verilog/csg_guard_if.sv
// Purpose: Carrier between the core registers and the stack guard.
// Assumes: One clock domain.
// Notes:   Core drives the address check, guard returns trap pulses.
`timescale 1ns/10ps
interface csg_guard_if;
  logic eaValid;
  logic eaIsPush;
  csg_pkg::csg_word_t effAddr;
  csg_pkg::csg_word_t limit;
  logic trapOver;
  logic trapUnder;

  modport core (
    output eaValid,
    output eaIsPush,
    output effAddr,
    output limit,
    input trapOver,
    input trapUnder
  );

  modport guard (
    input eaValid,
    input eaIsPush,
    input effAddr,
    input limit,
    output trapOver,
    output trapUnder
  );
endinterface

// ===== verilog/csg_stack_guard.sv
// Purpose: Compares each stack-pointer address against the floor, and push addresses also against the limit.
// Assumes: Address arrives in the cycle it is generated.
// Notes:   Trap pulses are registered, one cycle wide.
`timescale 1ns/10ps
`include "csg_defs.svh"
module csg_stack_guard (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Check path
  csg_guard_if.guard chk
);
  import csg_pkg::*;

  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  logic overHit;
  logic underHit;
  logic trapOver_q;
  logic trapUnder_q;

  // (RQ16) only push addresses checked against limit
  // (RQ17) equal to limit passes, beyond traps
  assign overHit = chk.eaValid && chk.eaIsPush && (chk.effAddr > chk.limit);
  // (RQ18) below floor traps
  assign underHit = chk.eaValid && (chk.effAddr < `CSG_STACK_FLOOR);

  // ----------------------------------------------------------------------
  // Trap pulses
  // ----------------------------------------------------------------------
  // (RQ21) one-cycle trap next edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trapOver_q <= 1'b0;
      trapUnder_q <= 1'b0;
    end else begin
      trapOver_q <= overHit;
      trapUnder_q <= underHit;
    end
  end

  assign chk.trapOver = trapOver_q;
  assign chk.trapUnder = trapUnder_q;
endmodule

// ===== verilog/csg_top.sv
// Purpose: Processor status flags, priority level and software stack
//          control with overflow and underflow trapping.
// Assumes: Datapath inputs are on sys_clk; AHB-Lite single word access.
// Notes:   Zero-wait-state slave, always OKAY.
//
// Behaviour
// (RQ1) Status bits 7:5 hold priority field, values 0 to 7.
// (RQ2) Core control msb prefixes field; set means levels 8-15, user blocked.
// (RQ3) Field 111 means level 7 or 15; all user interrupts blocked.
// (RQ4) Priority field ignores software writes while nesting disable is set.
// (RQ5) Status bit 4 mirrors repeat loop activity; read only.
// (RQ6) Status bit 3 set on negative ALU result, else cleared.
// (RQ7) Status bit 2 set on signed overflow, else cleared.
// (RQ8) Status bit 1 is sticky zero; nonzero result of sticky op clears.
// (RQ9) Status bit 0 set on carry out of msb, else cleared.
// (RQ10) Saturation bits read or cleared only; combined clear clears both.
// (RQ11) Stack pointer addresses first free word; stack grows upward.
// (RQ12) Pop decrements before read; push increments after write.
// (RQ13) Call push of upper PC zero-extends; pushed top bit clear.
// (RQ14) Exception push puts status low byte beside upper PC.
// (RQ15) Stack limit has no reset value; its bit 0 reads zero.
// (RQ16) Every stack-pointer address is compared against the limit; the code compares only push addresses against it.
// (RQ17) Push at limit passes; next push beyond limit traps.
// (RQ18) Stack address below 0x0800 raises underflow trap.
// (RQ19) Software avoids stack-pointer read right after limit write.
// (RQ20) Core control bit 3 holds priority msb; one means above 7.
// (RQ21) Each stack error is a one-cycle trap at the next edge.
`timescale 1ns/10ps
`include "csg_defs.svh"
module csg_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // ALU flag update
  input wire logic aluValid,
  input wire logic aluIsSub,
  input wire logic aluZeroSticky,
  input wire logic [15:0] aluOpA,
  input wire logic [15:0] aluOpB,
  // Core events
  input wire logic repeatActive,
  input wire logic accASat,
  input wire logic accBSat,
  input wire logic iplLoad,
  input wire logic [2:0] iplValue,
  input wire logic prioMsbSet,
  // Stack requests
  input wire logic pushReq,
  input wire csg_pkg::csg_push_e pushKind,
  input wire csg_pkg::csg_word_t pushData,
  input wire logic [15:0] pcLow,
  input wire logic [6:0] pcUpper,
  input wire logic popReq,
  input wire logic spEaValid,
  input wire logic spEaIsPush,
  input wire csg_pkg::csg_word_t spEa,
  // Stack memory
  output logic stkMemWe,
  output logic stkMemRe,
  output logic [15:0] stkMemAddr,
  output logic [15:0] stkMemWdata,
  // Status out
  output logic [15:0] statusWord,
  output logic [3:0] cpuPriority,
  output logic userIntBlocked,
  output logic [15:0] stackPointer,
  // Traps
  output logic stackTrap,
  output logic stackTrapUnder
);
  import csg_pkg::*;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic addrPhase;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] hrdata_q;
  logic [7:0] rdOfs;
  logic [15:0] rdWord;
  logic [15:0] wrData;
  logic wrSr;
  logic wrCore;
  logic wrIntc;
  logic wrSp;
  logic wrLim;

  assign addrPhase = hsel && htrans[1] && hready;
  assign rdOfs = haddr[7:0];
  assign wrData = hwdata[15:0];
  assign wrSr = wrPend_q && (wrAddr_q == `CSG_SR_OFS);
  assign wrCore = wrPend_q && (wrAddr_q == `CSG_CORE_OFS);
  assign wrIntc = wrPend_q && (wrAddr_q == `CSG_INTC_OFS);
  assign wrSp = wrPend_q && (wrAddr_q == `CSG_SP_OFS);
  assign wrLim = wrPend_q && (wrAddr_q == `CSG_LIM_OFS);

  // No wait states, so the master never sees back-pressure
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= addrPhase && hwrite && (haddr[31:8] == 24'h000000);
      wrAddr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata_q <= {16'h0000, (haddr[31:8] == 24'h000000) ? rdWord : 16'h0000};
    end
  end

  // ----------------------------------------------------------------------
  // Status word state
  // ----------------------------------------------------------------------
  logic [2:0] iplField_q;
  logic [2:0] iplField_d;
  logic satA_q;
  logic satB_q;
  logic satAB_q;
  logic satClrAll;
  logic neg_q;
  logic ovf_q;
  logic zero_q;
  logic carry_q;
  logic neg_d;
  logic ovf_d;
  logic zero_d;
  logic carry_d;
  logic prioMsb_q;
  logic nestDis_q;
  logic stkErr_q;

  // ALU evaluation
  logic [15:0] opBEff;
  logic [16:0] aluSum;
  logic [15:0] aluRes;
  logic aluNeg;
  logic aluOvf;
  logic aluZero;

  assign opBEff = aluIsSub ? ~aluOpB : aluOpB;
  assign aluSum = {1'b0, aluOpA} + {1'b0, opBEff} + {16'h0000, aluIsSub};
  assign aluRes = aluSum[15:0];
  // (RQ6) sign of result
  assign aluNeg = aluRes[15];
  // (RQ7) sign flipped wrongly
  assign aluOvf = (aluOpA[15] == opBEff[15]) && (aluRes[15] != aluOpA[15]);
  assign aluZero = (aluRes == 16'h0000);

  always_comb begin
    neg_d = neg_q;
    ovf_d = ovf_q;
    zero_d = zero_q;
    carry_d = carry_q;
    if (aluValid) begin
      neg_d = aluNeg;
      ovf_d = aluOvf;
      // (RQ9) carry out of msb
      carry_d = aluSum[16];
      // (RQ8) sticky zero handling
      if (aluZeroSticky) begin
        zero_d = aluZero ? zero_q : 1'b0;
      end else begin
        zero_d = aluZero;
      end
    end else if (wrSr) begin
      neg_d = wrData[`CSG_SR_N];
      ovf_d = wrData[`CSG_SR_OV];
      zero_d = wrData[`CSG_SR_Z];
      carry_d = wrData[`CSG_SR_C];
    end
  end

  // (RQ4) write ignored under nesting disable
  assign iplField_d = iplLoad ? iplValue :
                      (wrSr && !nestDis_q) ? wrData[`CSG_SR_IPL_HI:`CSG_SR_IPL_LO] :
                      iplField_q;

  // (RQ10) combined clear also clears both
  assign satClrAll = wrSr && !wrData[`CSG_SR_SATAB];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      iplField_q <= 3'h0;
      neg_q <= 1'b0;
      ovf_q <= 1'b0;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end else begin
      // (RQ1) priority field storage
      iplField_q <= iplField_d;
      neg_q <= neg_d;
      ovf_q <= ovf_d;
      zero_q <= zero_d;
      carry_q <= carry_d;
    end
  end

  // Saturation bits: a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      satA_q <= 1'b0;
      satB_q <= 1'b0;
      satAB_q <= 1'b0;
    end else begin
      // (RQ10) clear only, set by hardware
      satA_q <= accASat || (satA_q && !(satClrAll || (wrSr && !wrData[`CSG_SR_SATA])));
      satB_q <= accBSat || (satB_q && !(satClrAll || (wrSr && !wrData[`CSG_SR_SATB])));
      satAB_q <= accASat || accBSat || (satAB_q && !satClrAll);
    end
  end

  // ----------------------------------------------------------------------
  // Core and interrupt control bits
  // ----------------------------------------------------------------------
  logic trapAny;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prioMsb_q <= 1'b0;
      nestDis_q <= 1'b0;
      stkErr_q <= 1'b0;
    end else begin
      // (RQ20) msb held in control bit 3
      prioMsb_q <= prioMsbSet || (prioMsb_q && !(wrCore && !wrData[`CSG_CORE_PMSB]));
      nestDis_q <= wrIntc ? wrData[`CSG_INTC_NSTD] : nestDis_q;
      stkErr_q <= trapAny || (stkErr_q && !(wrIntc && !wrData[`CSG_INTC_STKE]));
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointer and limit
  // ----------------------------------------------------------------------
  csg_word_t spReg_q;
  csg_word_t spReg_d;
  csg_word_t limit_q;
  csg_word_t spDec;
  csg_word_t spInc;
  csg_word_t pushWord;
  logic doPush;
  logic doPop;

  // Push wins if the datapath raises both in one cycle
  assign doPush = pushReq;
  assign doPop = popReq && !pushReq;
  // (RQ12) pre-decrement pop, post-increment push
  assign spDec = spReg_q - `CSG_STACK_STEP;
  assign spInc = spReg_q + `CSG_STACK_STEP;

  // (RQ11) pointer moves upward on push
  assign spReg_d = doPush ? spInc :
                   doPop ? spDec :
                   wrSp ? {wrData[15:1], 1'b0} :
                   spReg_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spReg_q <= `CSG_STACK_FLOOR;
    end else begin
      spReg_q <= spReg_d;
    end
  end

  // (RQ15) no reset, bit 0 forced low
  always_ff @(posedge sys_clk) begin
    if (wrLim) begin
      limit_q <= {wrData[15:1], 1'b0};
    end
  end

  // Pushed word by kind
  always_comb begin
    case (pushKind)
      CSG_PUSH_DATA: pushWord = pushData;
      CSG_PUSH_PCLO: pushWord = pcLow;
      // (RQ13) zero-extend upper PC
      CSG_PUSH_CALLHI: pushWord = {9'h000, pcUpper};
      // (RQ14) status low byte beside upper PC
      CSG_PUSH_EXCHI: pushWord = {statusWord[7:0], 1'b0, pcUpper};
      default: pushWord = pushData;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stkMemWe <= 1'b0;
      stkMemRe <= 1'b0;
      stkMemAddr <= 16'h0000;
      stkMemWdata <= 16'h0000;
    end else begin
      stkMemWe <= doPush;
      stkMemRe <= doPop;
      stkMemAddr <= doPush ? spReg_q : (doPop ? spDec : stkMemAddr);
      stkMemWdata <= doPush ? pushWord : stkMemWdata;
    end
  end

  // ----------------------------------------------------------------------
  // Stack guard
  // ----------------------------------------------------------------------
  csg_guard_if chk ();

  // (RQ16) internal and datapath addresses checked
  assign chk.eaValid = doPush || doPop || spEaValid;
  assign chk.eaIsPush = doPush || (!doPop && spEaIsPush);
  assign chk.effAddr = doPush ? spReg_q : (doPop ? spDec : spEa);
  // Limit change reaches the compare at once; see the limit-write hazard
  assign chk.limit = limit_q;

  csg_stack_guard u_guard (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .chk(chk)
  );

  // (RQ21) trap pulses to exception logic
  assign trapAny = chk.trapOver || chk.trapUnder;
  assign stackTrap = trapAny;
  assign stackTrapUnder = chk.trapUnder;

  // ----------------------------------------------------------------------
  // Status outputs and readback
  // ----------------------------------------------------------------------
  // (RQ5) repeat flag read only
  assign statusWord = {2'b00, satA_q, satB_q, 1'b0, satAB_q, 2'b00,
                       iplField_q, repeatActive, neg_q, ovf_q, zero_q, carry_q};

  // (RQ2) msb prefixes field
  assign cpuPriority = {prioMsb_q, iplField_q};
  // (RQ3) top level blocks user interrupts
  assign userIntBlocked = prioMsb_q || (iplField_q == `CSG_IPL_TOP);
  assign stackPointer = spReg_q;

  always_comb begin
    case (rdOfs)
      `CSG_SR_OFS: rdWord = statusWord;
      `CSG_CORE_OFS: rdWord = {12'h000, prioMsb_q, 3'h0};
      `CSG_INTC_OFS: rdWord = {nestDis_q, 12'h000, stkErr_q, 2'b00};
      `CSG_SP_OFS: rdWord = spReg_q;
      `CSG_LIM_OFS: rdWord = limit_q;
      default: rdWord = 16'h0000;
    endcase
  end
endmodule

// ===== verif/csg_top_sva.sv
// Purpose: Port-level checks for the status and stack guard block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   The limit compare is judged in the bench; the limit is no port.
`timescale 1ns/10ps
module csg_top_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Datapath inputs
  input wire logic aluValid,
  input wire logic aluIsSub,
  input wire logic aluZeroSticky,
  input wire logic [15:0] aluOpA,
  input wire logic [15:0] aluOpB,
  input wire logic repeatActive,
  input wire logic pushReq,
  input wire csg_pkg::csg_push_e pushKind,
  input wire logic [6:0] pcUpper,
  input wire logic popReq,
  input wire logic spEaValid,
  input wire csg_pkg::csg_word_t spEa,
  // Design outputs
  input wire logic stkMemWe,
  input wire logic stkMemRe,
  input wire logic [15:0] stkMemAddr,
  input wire logic [15:0] stkMemWdata,
  input wire logic [15:0] statusWord,
  input wire logic [3:0] cpuPriority,
  input wire logic userIntBlocked,
  input wire logic [15:0] stackPointer,
  input wire logic stackTrap,
  input wire logic stackTrapUnder
);
  import csg_pkg::*;
  // ----
  // Reference arithmetic
  // ----
  logic [15:0] opB;
  logic [16:0] aluSum;
  logic aluOvf;
  // Subtract as A + ~B + 1, so carry means no borrow
  assign opB = aluIsSub ? ~aluOpB : aluOpB;
  assign aluSum = {1'b0, aluOpA} + {1'b0, opB} + {16'h0, aluIsSub};
  assign aluOvf = (aluOpA[15] == opB[15]) && (aluSum[15] != aluOpA[15]);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence pushTaken;
    pushReq;
  endsequence
  sequence popTaken;
    popReq && !pushReq;
  endsequence
  flag_nc_a: assert property (
    aluValid |=> statusWord[3] == $past(aluSum[15]) && statusWord[0] == $past(aluSum[16]))
    else $error("negative or carry flag wrong");
  flag_ov_a: assert property (
    aluValid |=> statusWord[2] == $past(aluOvf)) else $error("overflow flag wrong");
  flag_zero_a: assert property (
    aluValid |=> statusWord[1] == ($past(aluSum[15:0]) == 16'h0000 &&
    (!$past(aluZeroSticky) || $past(statusWord[1])))) else $error("zero flag wrong");
  push_move_a: assert property (
    pushTaken |=> stkMemWe && stkMemAddr == $past(stackPointer) &&
    stackPointer == $past(stackPointer) + 16'h0002) else $error("push address wrong");
  pop_move_a: assert property (
    popTaken |=> stkMemRe && stkMemAddr == $past(stackPointer) - 16'h0002 &&
    stackPointer == $past(stackPointer) - 16'h0002) else $error("pop address wrong");
  call_word_a: assert property (
    pushTaken ##0 pushKind == CSG_PUSH_CALLHI |=> stkMemWdata == {9'h000, $past(pcUpper)})
    else $error("call word wrong");
  exc_word_a: assert property (
    pushTaken ##0 pushKind == CSG_PUSH_EXCHI |=>
    stkMemWdata == {$past(statusWord[7:0]), 1'b0, $past(pcUpper)}) else $error("exception word wrong");
  ea_under_a: assert property (
    spEaValid && !pushReq && !popReq && spEa < 16'h0800 |=> stackTrap && stackTrapUnder)
    else $error("underflow not trapped");
  trap_cause_a: assert property (
    stackTrap |-> $past(pushReq || popReq || spEaValid)) else $error("trap without access");
  under_part_a: assert property (
    stackTrapUnder |-> stackTrap) else $error("underflow without trap");
  prio_field_a: assert property (
    cpuPriority[2:0] == statusWord[7:5]) else $error("priority field mismatch");
  user_block_a: assert property (
    userIntBlocked == (cpuPriority[3] || cpuPriority[2:0] == 3'h7)) else $error("block wrong");
  repeat_bit_a: assert property (
    statusWord[4] == repeatActive) else $error("repeat bit wrong");
endmodule
bind csg_top csg_top_sva u_sva (.*);

// ===== verif/csg_stack_model.sv
// Purpose: Stack memory standing behind the block's memory port.
// Assumes: Write and read strobes are one-cycle registered pulses.
// Notes:   Unwritten places read back the inverted address, never old data;
//          the read word holds between reads.
`timescale 1ns/10ps
module csg_stack_model (
  // Clock
  input wire logic sys_clk,
  // Memory port
  input wire logic stkMemWe,
  input wire logic stkMemRe,
  input wire logic [15:0] stkMemAddr,
  input wire logic [15:0] stkMemWdata,
  // Read side
  output logic [15:0] popWord
);
  logic [15:0] mem [logic [15:0]];
  always @(posedge sys_clk) begin
    if (stkMemWe) begin
      mem[stkMemAddr] = stkMemWdata;
    end
    if (stkMemRe) begin
      popWord <= mem.exists(stkMemAddr) ? mem[stkMemAddr] : ~stkMemAddr;
    end
  end
endmodule

// ===== verif/cpu_status_and_stack_guard_bench.sv
// Purpose: Self-checking bench for the status and stack guard block.
// Assumes: Zero-wait AHB-Lite slave; stack memory model on the far side.
// Notes:   Every scenario is its own task and judges its own results.
`timescale 1ns/10ps
module cpu_status_and_stack_guard_bench;
  import csg_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, aluValid = 1'b0, aluIsSub = 1'b0, aluZeroSticky = 1'b0;
  logic repeatActive = 1'b0, accASat = 1'b0, accBSat = 1'b0, iplLoad = 1'b0;
  logic prioMsbSet = 1'b0, pushReq = 1'b0, popReq = 1'b0, spEaValid = 1'b0, spEaIsPush = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, iplValue = 3'h0;
  logic [15:0] aluOpA = 16'h0, aluOpB = 16'h0, pcLow = 16'h4321;
  logic [6:0] pcUpper = 7'h55;
  csg_push_e pushKind = CSG_PUSH_DATA;
  csg_word_t pushData = 16'h1234, spEa = 16'h0;
  logic hready, hreadyout, hresp, stkMemWe, stkMemRe, userIntBlocked, stackTrap, stackTrapUnder;
  logic [15:0] stkMemAddr, stkMemWdata, statusWord, stackPointer, popWord;
  logic [3:0] cpuPriority;
  int badCount = 0;
  int samplesChecked = 0;
  // ----
  // Clock, design and far side
  // ----
  always #5 sys_clk = ~sys_clk;
  assign hready = hreadyout;
  csg_top u_dut (.*);
  csg_stack_model u_mem (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    samplesChecked++;
    if (seen !== want) begin
      badCount++;
      $display("CHECK FAILED %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  // Holds each phase until hready is seen high; read data taken at the last edge
  task automatic busXfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge sys_clk);
    while (!hready) @(posedge sys_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge sys_clk);
    while (!hready) @(posedge sys_clk);
    rd = hrdata;
    #1;
  endtask
  task automatic eaPulse(input csg_word_t a, input logic p);
    @(posedge sys_clk);
    spEaValid <= 1'b1;
    spEaIsPush <= p;
    spEa <= a;
    @(posedge sys_clk);
    spEaValid <= 1'b0;
    #1;
  endtask
  task automatic testReset();
    check(stackPointer, 16'h0800, "sp reset");
    check(statusWord, 16'h0000, "sr reset");
    check({hreadyout, hresp}, 2'b10, "bus ready okay");
    busXfer(1'b1, 32'h14, 32'hffff);
    busXfer(1'b0, 32'h14, 32'h0);
    check(rd, 32'h0, "unmapped read");
    check(statusWord, 16'h0000, "unmapped write");
  endtask
  task automatic testPriority();
    for (int v = 0; v < 8; v++) begin
      busXfer(1'b1, 32'h0, {24'h0, v[2:0], 5'h0});
      check(cpuPriority, {1'b0, v[2:0]}, "prio");
      check(userIntBlocked, v == 7, "block");
    end
    @(posedge sys_clk);
    prioMsbSet <= 1'b1;
    @(posedge sys_clk);
    prioMsbSet <= 1'b0;
    #1;
    check(cpuPriority, 4'hf, "prio msb");
    busXfer(1'b1, 32'h0, 32'h0);
    check(userIntBlocked, 1'b1, "msb blocks");
    busXfer(1'b0, 32'h4, 32'h0);
    check(rd, 32'h8, "core msb");
    busXfer(1'b1, 32'h4, 32'h0);
    check(cpuPriority, 4'h0, "msb clear");
    busXfer(1'b1, 32'h8, 32'h8000);
    busXfer(1'b1, 32'h0, 32'h00e0);
    check(cpuPriority, 4'h0, "field locked");
    @(posedge sys_clk);
    iplLoad <= 1'b1;
    iplValue <= 3'h3;
    @(posedge sys_clk);
    iplLoad <= 1'b0;
    #1;
    check(cpuPriority, 4'h3, "hardware load");
    busXfer(1'b1, 32'h8, 32'h0);
    busXfer(1'b1, 32'h0, 32'h00e0);
    check(cpuPriority, 4'h7, "field free");
  endtask
  task automatic testAlu();
    // Order matters: the sticky rows with a zero result lean on the zero flag left by the row before
    logic [37:0] ops [6] = '{{16'hffff, 16'h0001, 2'b00, 4'b0011},
      {16'h0003, 16'h0003, 2'b11, 4'b0011}, {16'h7fff, 16'h0001, 2'b01, 4'b1100},
      {16'h0000, 16'h0000, 2'b01, 4'b0000}, {16'h8000, 16'h0001, 2'b10, 4'b0101},
      {16'h0002, 16'h0005, 2'b10, 4'b1000}};
    foreach (ops[i]) begin
      @(posedge sys_clk);
      {aluOpA, aluOpB, aluIsSub, aluZeroSticky} <= ops[i][37:4];
      aluValid <= 1'b1;
      @(posedge sys_clk);
      aluValid <= 1'b0;
      #1;
      check(statusWord[3:0], ops[i][3:0], "alu flags");
    end
  endtask
  task automatic testSat();
    @(posedge sys_clk);
    accASat <= 1'b1;
    accBSat <= 1'b1;
    repeatActive <= 1'b1;
    @(posedge sys_clk);
    accASat <= 1'b0;
    accBSat <= 1'b0;
    busXfer(1'b1, 32'h0, 32'hffff);
    busXfer(1'b0, 32'h0, 32'h0);
    check(rd, 32'h34ff, "sat set");
    busXfer(1'b1, 32'h0, 32'hdfff);
    busXfer(1'b0, 32'h0, 32'h0);
    check(rd, 32'h14ff, "clear one");
    busXfer(1'b1, 32'h0, 32'hfbff);
    busXfer(1'b0, 32'h0, 32'h0);
    check(rd, 32'h00ff, "clear all");
    @(posedge sys_clk);
    repeatActive <= 1'b0;
    busXfer(1'b1, 32'h0, 32'hffff);
    check(statusWord, 16'h00ef, "no set");
  endtask
  task automatic testStack();
    csg_word_t want [4] = '{16'h1234, 16'h4321, 16'ha555, 16'h0055};
    busXfer(1'b1, 32'h10, 32'h0fff);
    busXfer(1'b0, 32'h10, 32'h0);
    check(rd, 32'h0ffe, "limit bit0");
    busXfer(1'b1, 32'h0, 32'h00a5);
    busXfer(1'b1, 32'hc, 32'h0a00);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      pushReq <= 1'b1;
      pushKind <= csg_push_e'(k);
    end
    @(posedge sys_clk);
    pushReq <= 1'b0;
    #1;
    check(stackPointer, 16'h0a08, "sp up");
    for (int k = 3; k >= 0; k--) begin
      @(posedge sys_clk);
      popReq <= 1'b1;
      @(posedge sys_clk);
      popReq <= 1'b0;
      @(posedge sys_clk);
      #1;
      check(popWord, want[k], "popped word");
    end
    check(stackPointer, 16'h0a00, "sp down");
  endtask
  task automatic testTrap();
    busXfer(1'b1, 32'h10, 32'h0900);
    // no read through the stack pointer straight after the limit write
    busXfer(1'b1, 32'hc, 32'h0900);
    @(posedge sys_clk);
    pushReq <= 1'b1;
    pushKind <= CSG_PUSH_DATA;
    @(posedge sys_clk);
    #1;
    check(stackTrap, 1'b0, "at limit");
    @(posedge sys_clk);
    pushReq <= 1'b0;
    #1;
    check({stackTrap, stackTrapUnder}, 2'b10, "beyond limit");
    @(posedge sys_clk);
    #1;
    check(stackTrap, 1'b0, "one cycle");
    busXfer(1'b0, 32'h8, 32'h0);
    check(rd, 32'h4, "error bit");
    busXfer(1'b1, 32'h8, 32'h0);
    eaPulse(16'h0904, 1'b1);
    check(stackTrap, 1'b1, "ea over");
    eaPulse(16'h0800, 1'b0);
    check(stackTrap, 1'b0, "floor ok");
    eaPulse(16'h07fe, 1'b0);
    check(stackTrapUnder, 1'b1, "ea under");
    busXfer(1'b1, 32'hc, 32'h0800);
    @(posedge sys_clk);
    popReq <= 1'b1;
    @(posedge sys_clk);
    popReq <= 1'b0;
    #1;
    check({stackTrap, stackTrapUnder}, 2'b11, "pop under");
  endtask
  task automatic conclude();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    testReset();
    testPriority();
    testAlu();
    testSat();
    testStack();
    testTrap();
    conclude();
  end
  // All scenarios take well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    conclude();
  end
endmodule
